//--- rtl/eeprom_host_pkg.sv
package eeprom_host_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 8;
  localparam int TIMER_WIDTH = 23;
  localparam logic [7:0] ERASED_WORD = 8'hFF;
  // Least times round up to whole cycles
  localparam int SETUP_NS = 10;
  localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_NS = 300;
  localparam int READ_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_NS = 150;
  localparam int PULSE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_HOLD_NS = 10;
  localparam int HOLD_CYCLES = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_ASSERT_DELAY_NS = 100;
  localparam int BUSY_ASSERT_CYCLES =
    (BUSY_ASSERT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCKOUT_MS = 10;
  localparam int LOCKOUT_CYCLES_DOC = (LOCKOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLE_MAX_MS = 40;
  localparam int WRITE_TIMEOUT_CYCLES_DOC =
    (WRITE_CYCLE_MAX_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_LOCK_WAIT = 10'h002,
    ST_RD_SETUP = 10'h004,
    ST_RD_WAIT = 10'h008,
    ST_WR_SETUP = 10'h010,
    ST_WR_PULSE = 10'h020,
    ST_WR_RELEASE = 10'h040,
    ST_BUSY_WAIT = 10'h080,
    ST_POLL = 10'h100
  } state_type;
endpackage

//--- rtl/delay_timer.sv
`timescale 1ns/1ns
`default_nettype none
module delay_timer #(
  parameter int WIDTH = 23,
  parameter logic [WIDTH-1:0] START = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic done
);
  logic [WIDTH-1:0] count;

  // Reset reloads START so a power-up hold-off runs without any command
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count <= START;
    end
    else if (load)
    begin
      count <= load_value;
    end
    else if (count != '0)
    begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0);
endmodule
`default_nettype wire

//--- rtl/eeprom_host.sv
// Notes on behaviour
// - Host holds address steady, strobe high, reading
// - Host keeps gate high except while reading
// - Strobe mode: address on fall, data on rise
// - Select mode: strobe low first, select latches
`timescale 1ns/1ns
`default_nettype none
module eeprom_host #(
  parameter int ADDR_WIDTH = eeprom_host_pkg::ADDR_WIDTH,
  parameter int DATA_WIDTH = eeprom_host_pkg::DATA_WIDTH,
  parameter int TIMER_WIDTH = eeprom_host_pkg::TIMER_WIDTH,
  parameter int LOCKOUT_CYCLES = eeprom_host_pkg::LOCKOUT_CYCLES_DOC,
  parameter int WRITE_TIMEOUT_CYCLES = eeprom_host_pkg::WRITE_TIMEOUT_CYCLES_DOC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [ADDR_WIDTH-1:0] cmd_addr,
  input wire logic [DATA_WIDTH-1:0] cmd_wdata,
  input wire logic cmd_select_mode,
  output logic rsp_valid,
  output logic [DATA_WIDTH-1:0] rsp_rdata,
  output logic rsp_timeout,
  output logic write_unlocked,
  output logic [ADDR_WIDTH-1:0] addr_lines,
  output logic [DATA_WIDTH-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [DATA_WIDTH-1:0] data_lines_in,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  input wire logic prog_ready
);
  localparam int MAX_COUNT = (WRITE_TIMEOUT_CYCLES > LOCKOUT_CYCLES) ?
    WRITE_TIMEOUT_CYCLES : LOCKOUT_CYCLES;

  generate
    if (ADDR_WIDTH != 8 || DATA_WIDTH != 8)
    begin : g_bad_width
      $error("Device has 256 words of 8 bits");
    end
    if (TIMER_WIDTH < 8 || TIMER_WIDTH > 31 || MAX_COUNT >= (1 << TIMER_WIDTH)
        || LOCKOUT_CYCLES < 1 || WRITE_TIMEOUT_CYCLES < 1)
    begin : g_bad_timer
      $error("Timer too narrow for the counts");
    end
  endgenerate

  eeprom_host_pkg::state_type state;
  eeprom_host_pkg::state_type next_state;
  logic op_select_mode;
  logic [ADDR_WIDTH-1:0] op_addr;
  logic [DATA_WIDTH-1:0] op_data;
  logic take;
  logic is_read;
  logic timer_load;
  logic [TIMER_WIDTH-1:0] timer_value;
  logic timer_done;
  logic lockout_done;
  logic [ADDR_WIDTH-1:0] cur_addr;
  logic [DATA_WIDTH-1:0] cur_data;
  logic cur_select_mode;

  assign take = (state == eeprom_host_pkg::ST_IDLE) && cmd_valid && cmd_ready;
  assign is_read = (cmd_op == eeprom_host_pkg::OP_READ);
  assign cur_addr = take ? cmd_addr : op_addr;
  // Erase writes the all-ones word, which is the erased state
  assign cur_data = !take ? op_data :
    (cmd_op == eeprom_host_pkg::OP_ERASE) ? eeprom_host_pkg::ERASED_WORD : cmd_wdata;
  assign cur_select_mode = take ? cmd_select_mode : op_select_mode;

  delay_timer #(.WIDTH(TIMER_WIDTH), .START('0)) u_step_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(timer_load),
    .load_value(timer_value),
    .done(timer_done)
  );

  // Counts from reset, standing in for supply-up
  delay_timer #(.WIDTH(TIMER_WIDTH), .START(TIMER_WIDTH'(LOCKOUT_CYCLES))) u_lockout (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(1'b0),
    .load_value('0),
    .done(lockout_done)
  );

  always_comb
  begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = '0;
    case (state)
      eeprom_host_pkg::ST_IDLE:
      begin
        if (take && is_read)
        begin
          // Reads need no lockout wait
          next_state = eeprom_host_pkg::ST_RD_SETUP;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(eeprom_host_pkg::SETUP_CYCLES);
        end
        else if (take && lockout_done)
        begin
          next_state = eeprom_host_pkg::ST_WR_SETUP;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(eeprom_host_pkg::SETUP_CYCLES);
        end
        else if (take)
        begin
          next_state = eeprom_host_pkg::ST_LOCK_WAIT;
        end
      end
      eeprom_host_pkg::ST_LOCK_WAIT:
      begin
        if (lockout_done)
        begin
          next_state = eeprom_host_pkg::ST_WR_SETUP;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(eeprom_host_pkg::SETUP_CYCLES);
        end
      end
      eeprom_host_pkg::ST_RD_SETUP:
      begin
        if (timer_done)
        begin
          next_state = eeprom_host_pkg::ST_RD_WAIT;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(eeprom_host_pkg::READ_CYCLES);
        end
      end
      eeprom_host_pkg::ST_RD_WAIT:
      begin
        if (timer_done)
        begin
          next_state = eeprom_host_pkg::ST_IDLE;
        end
      end
      eeprom_host_pkg::ST_WR_SETUP:
      begin
        if (timer_done)
        begin
          next_state = eeprom_host_pkg::ST_WR_PULSE;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(eeprom_host_pkg::PULSE_CYCLES);
        end
      end
      eeprom_host_pkg::ST_WR_PULSE:
      begin
        if (timer_done)
        begin
          next_state = eeprom_host_pkg::ST_WR_RELEASE;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(eeprom_host_pkg::HOLD_CYCLES);
        end
      end
      eeprom_host_pkg::ST_WR_RELEASE:
      begin
        if (timer_done)
        begin
          // Ready is not trusted until the busy delay has passed
          next_state = eeprom_host_pkg::ST_BUSY_WAIT;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(eeprom_host_pkg::BUSY_ASSERT_CYCLES);
        end
      end
      eeprom_host_pkg::ST_BUSY_WAIT:
      begin
        if (timer_done)
        begin
          next_state = eeprom_host_pkg::ST_POLL;
          timer_load = 1'b1;
          timer_value = TIMER_WIDTH'(WRITE_TIMEOUT_CYCLES);
        end
      end
      eeprom_host_pkg::ST_POLL:
      begin
        // Device ignores access while busy, so wait for ready
        if (prog_ready || timer_done)
        begin
          next_state = eeprom_host_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_state = eeprom_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= eeprom_host_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      op_select_mode <= 1'b0;
      op_addr <= '0;
      op_data <= '0;
    end
    else if (take)
    begin
      op_select_mode <= cmd_select_mode;
      op_addr <= cmd_addr;
      op_data <= cur_data;
    end
  end

  // New commands only while the device reports ready
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmd_ready <= 1'b0;
      write_unlocked <= 1'b0;
    end
    else
    begin
      cmd_ready <= (next_state == eeprom_host_pkg::ST_IDLE) && !take && prog_ready;
      write_unlocked <= lockout_done;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_timeout <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (state == eeprom_host_pkg::ST_RD_WAIT && timer_done)
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_lines_in;
        rsp_timeout <= 1'b0;
      end
      else if (state == eeprom_host_pkg::ST_POLL && (prog_ready || timer_done))
      begin
        rsp_valid <= 1'b1;
        rsp_timeout <= !prog_ready;
      end
    end
  end

  // Pins follow the next state so every pin comes straight from a flop
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      addr_lines <= '0;
      data_lines_out <= '0;
      data_lines_oe <= 1'b0;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end
    else
    begin
      addr_lines <= cur_addr;
      data_lines_out <= cur_data;
      data_lines_oe <= 1'b0;
      chip_select_n <= 1'b1;
      output_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
      case (next_state)
        eeprom_host_pkg::ST_RD_SETUP:
        begin
          chip_select_n <= 1'b0;
        end
        eeprom_host_pkg::ST_RD_WAIT:
        begin
          // Address, select and gate all held steady for the access
          chip_select_n <= 1'b0;
          output_gate_n <= 1'b0;
        end
        eeprom_host_pkg::ST_WR_SETUP:
        begin
          data_lines_oe <= 1'b1;
          chip_select_n <= cur_select_mode;
          write_strobe_n <= !cur_select_mode;
        end
        eeprom_host_pkg::ST_WR_PULSE:
        begin
          data_lines_oe <= 1'b1;
          chip_select_n <= 1'b0;
          write_strobe_n <= 1'b0;
        end
        eeprom_host_pkg::ST_WR_RELEASE:
        begin
          data_lines_oe <= 1'b1;
          chip_select_n <= cur_select_mode;
          write_strobe_n <= !cur_select_mode;
        end
        default:
        begin
          data_lines_oe <= 1'b0;
        end
      endcase
    end
  end

  logic [7:0] gate_low_cycles;

  // Counts gate-low cycles for the access-time check; saturates rather than wrapping
  always_ff @(posedge clk_sys)
  begin
    if (rst || output_gate_n)
    begin
      gate_low_cycles <= '0;
    end
    else if (gate_low_cycles != '1)
    begin
      gate_low_cycles <= gate_low_cycles + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_no_contention;
    !output_gate_n |-> !data_lines_oe;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("Data driven while gated");

  property p_gate_high_on_write;
    !write_strobe_n |-> output_gate_n && data_lines_oe;
  endproperty
  a_gate_high_on_write: assert property (p_gate_high_on_write) else $error("Strobe with gate low");

  property p_read_strobe_high;
    !output_gate_n |-> write_strobe_n && !chip_select_n;
  endproperty
  a_read_strobe_high: assert property (p_read_strobe_high) else $error("Bad read controls");

  property p_read_addr_stable;
    !output_gate_n && $past(!output_gate_n) |-> $stable(addr_lines);
  endproperty
  a_read_addr_stable: assert property (p_read_addr_stable) else $error("Address moved in read");

  property p_read_access_time;
    $rose(output_gate_n) |-> gate_low_cycles >= eeprom_host_pkg::READ_CYCLES;
  endproperty
  a_read_access_time: assert property (p_read_access_time) else $error("Read cut short");

  property p_strobe_mode_fall;
    $fell(write_strobe_n) && !op_select_mode |-> !chip_select_n ##1 !write_strobe_n [*8];
  endproperty
  a_strobe_mode_fall: assert property (p_strobe_mode_fall) else $error("Strobe pulse bad");

  property p_select_mode_order;
    $fell(chip_select_n) && op_select_mode && state != eeprom_host_pkg::ST_RD_SETUP
      |-> !write_strobe_n;
  endproperty
  a_select_mode_order: assert property (p_select_mode_order) else $error("Select before strobe");

  property p_lockout;
    !write_strobe_n |-> lockout_done;
  endproperty
  a_lockout: assert property (p_lockout) else $error("Write during lockout");

  property p_busy_delay;
    $rose(write_strobe_n) |-> (!cmd_ready && !rsp_valid) [*8];
  endproperty
  a_busy_delay: assert property (p_busy_delay) else $error("Ready sampled too early");

  property p_ready_gated;
    $rose(cmd_ready) |-> $past(prog_ready);
  endproperty
  a_ready_gated: assert property (p_ready_gated) else $error("Accepted while busy");

  c_read: cover property (take && is_read ##[1:60] rsp_valid);
  c_strobe_write: cover property ($fell(write_strobe_n) && !op_select_mode);
  c_select_write: cover property ($fell(chip_select_n) && op_select_mode && !write_strobe_n);
  c_timeout: cover property (rsp_valid && rsp_timeout);
endmodule
`default_nettype wire

//--- bench/eeprom_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_device_model #(
  parameter int LOCK_NS = 300,
  parameter int PROG_NS = 1500,
  parameter int SLOW_NS = 5000
) (
  input wire logic [7:0] addr_lines,
  input wire logic [7:0] data_wire,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic stall,
  output logic [7:0] dev_data,
  output logic dev_oe,
  output logic prog_ready
);
  logic [7:0] mem [256];
  logic [7:0] lat_addr;
  logic [7:0] lat_data;
  logic [7:0] data_late;
  logic read_ok;
  logic cs_late;
  logic we_late;
  logic may_write;
  time last_chg;
  event go;
  // Delayed copies let a latch edge see levels from just before a joint change
  assign #1 cs_late = chip_select_n;
  assign #1 we_late = write_strobe_n;
  assign #1 data_late = data_wire;
  // Time alone never wakes a continuous assign, so the lockout is tested at the latch edge
  assign may_write = prog_ready && output_gate_n;
  assign dev_oe = !chip_select_n && !output_gate_n && write_strobe_n && prog_ready;
  // Until access time has passed the pins show wrong data, not the old word
  assign dev_data = read_ok ? mem[addr_lines] : ~mem[addr_lines];
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'hFF;
    end
    prog_ready = 1'b1;
    read_ok = 1'b0;
    last_chg = 0;
  end
  always @(addr_lines or chip_select_n or output_gate_n)
  begin
    last_chg = $time;
  end
  always
  begin
    #1;
    read_ok = ($time - last_chg >= 300);
  end
  always @(negedge write_strobe_n)
  begin
    if (!chip_select_n)
    begin
      lat_addr = addr_lines;
    end
  end
  always @(posedge write_strobe_n)
  begin
    if (!cs_late && may_write && ($time >= LOCK_NS))
    begin
      lat_data = data_late;
      ->go;
    end
  end
  always @(negedge chip_select_n)
  begin
    if (!write_strobe_n)
    begin
      lat_addr = addr_lines;
    end
  end
  always @(posedge chip_select_n)
  begin
    if (!we_late && may_write && ($time >= LOCK_NS))
    begin
      lat_data = data_late;
      ->go;
    end
  end
  always
  begin
    @go;
    #50 prog_ready = 1'b0;
    #(stall ? SLOW_NS : PROG_NS);
    mem[lat_addr] = lat_data;
    prog_ready = 1'b1;
  end
endmodule
`default_nettype wire

//--- bench/eeprom_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_host_tb;
  localparam int LOCK_CYC = 50;
  localparam int TMO_CYC = 400;
  localparam int LIMIT = 20000;
  logic clk_sys, rst, cmd_valid, cmd_ready, cmd_select_mode, rsp_valid, rsp_timeout;
  logic write_unlocked, data_lines_oe, chip_select_n, output_gate_n, write_strobe_n;
  logic prog_ready, stall, dev_oe, prev_read;
  logic [1:0] cmd_op;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, addr_lines, data_lines_out, data_wire;
  logic [7:0] dev_data, float_pat, prev_addr, rd;
  logic tmo;
  int err_total, total_checks, cyc;
  // Nobody driving: the wire wanders instead of keeping its last value
  assign data_wire = data_lines_oe ? data_lines_out : (dev_oe ? dev_data : float_pat);
  eeprom_host #(.LOCKOUT_CYCLES(LOCK_CYC), .WRITE_TIMEOUT_CYCLES(TMO_CYC)) i_eeprom_host (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_select_mode(cmd_select_mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_timeout(rsp_timeout), .write_unlocked(write_unlocked), .addr_lines(addr_lines),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .data_lines_in(data_wire),
    .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n), .prog_ready(prog_ready));
  eeprom_device_model i_eeprom_device_model (
    .addr_lines(addr_lines), .data_wire(data_wire), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .stall(stall),
    .dev_data(dev_data), .dev_oe(dev_oe), .prog_ready(prog_ready));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(negedge clk_sys)
  begin
    float_pat <= ~float_pat;
    cyc++;
    if (cyc > 3 && !rst && !output_gate_n)
    begin
      check({7'h00, write_strobe_n}, 8'h01, "strobe low in read");
      check({7'h00, data_lines_oe}, 8'h00, "host drives in read");
      if (prev_read)
        check(addr_lines, prev_addr, "address moved in read");
    end
    prev_read <= !output_gate_n;
    prev_addr <= addr_lines;
    if (cyc == LIMIT)
    begin
      err_total++;
      $display("[ERR] %0t run did not finish", $time);
      final_report();
    end
  end
  task automatic do_cmd(input logic [1:0] op, input logic [7:0] addr, input logic [7:0] wd,
    input logic mode);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    cmd_op = op;
    cmd_addr = addr;
    cmd_wdata = wd;
    cmd_select_mode = mode;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check({7'h00, rsp_valid}, 8'h01, "no response");
    rd = rsp_rdata;
    tmo = rsp_timeout;
  endtask
  task automatic t_idle();
    check({5'h00, chip_select_n, output_gate_n, write_strobe_n}, 8'h07, "pins idle");
    check({7'h00, data_lines_oe}, 8'h00, "data driven in idle");
    @(negedge clk_sys);
    check({7'h00, cmd_ready}, 8'h01, "not ready after reset");
  endtask
  task automatic t_lock_read();
    do_cmd(eeprom_host_pkg::OP_READ, 8'h00, 8'h00, 1'b0);
    check(rd, eeprom_host_pkg::ERASED_WORD, "erased read in lockout");
    check({7'h00, write_unlocked}, 8'h00, "unlocked too early");
  endtask
  task automatic t_writes();
    logic [1:0] ops [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
    logic [7:0] adr [4] = '{8'h00, 8'hFF, 8'h80, 8'h00};
    logic [7:0] dat [4] = '{8'h3C, 8'hC3, 8'h5A, 8'h00};
    logic [7:0] exp [4] = '{8'h3C, 8'hC3, 8'h5A, 8'hFF};
    for (int i = 0; i < 4; i++)
    begin
      do_cmd(ops[i], adr[i], dat[i], i[0]);
      check({7'h00, tmo}, 8'h00, "write timed out");
      check({7'h00, write_unlocked}, 8'h01, "still locked after write");
      do_cmd(eeprom_host_pkg::OP_READ, adr[i], 8'h00, 1'b0);
      check(rd, exp[i], "read back");
    end
    do_cmd(eeprom_host_pkg::OP_READ, 8'h01, 8'h00, 1'b0);
    check(rd, 8'hFF, "neighbour word changed");
  endtask
  task automatic t_slow();
    stall = 1'b1;
    do_cmd(eeprom_host_pkg::OP_WRITE, 8'h40, 8'h99, 1'b0);
    check({7'h00, tmo}, 8'h01, "slow write not flagged");
    @(negedge clk_sys);
    check({6'h00, cmd_ready, prog_ready}, 8'h00, "ready while busy");
    do_cmd(eeprom_host_pkg::OP_READ, 8'h40, 8'h00, 1'b0);
    check(rd, 8'h99, "slow write lost");
    stall = 1'b0;
  endtask
  initial
  begin
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    float_pat = 8'h5A;
    prev_read = 1'b0;
    prev_addr = 8'h00;
    rst = 1'b1;
    stall = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    cmd_select_mode = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    t_idle();
    t_lock_read();
    t_writes();
    t_slow();
    final_report();
  end
endmodule
`default_nettype wire
